// file: design/afe_cfg_params.svh
// constants for the upstream port analog front end and inter-chip configuration bank
// assumes byte addressing on the register port and 5-bit management indices
`ifndef AFE_CFG_PARAMS_SVH
`define AFE_CFG_PARAMS_SVH

`define REG_ADDR_W        12
`define AFE_CTRL_OFFSET   12'h0c8
`define PORT_EN_OFFSET    12'h140

`define HS_TERM_BIT       29
`define HS_SQUELCH_BIT    28
`define HS_DISC_BIT       27
`define SQU_TUNE_MSB      26
`define SQU_TUNE_LSB      24
`define SQU_TUNE_RESET    3'h0

`define PORT_MODE_BIT     24
`define DRV_IMP_BIT       18
`define SLEW_ADJ_BIT      17
`define DS_SWAP_BIT       16

`define PHY_IDX_CTRL      5'h00
`define PHY_IDX_RSVD_A    5'h0b
`define PHY_IDX_RSVD_B    5'h0c
`define PHY_IDX_MMD_CTRL  5'h0d
`define PHY_IDX_MMD_DATA  5'h0e
`define PHY_IDX_EXT_LO    5'h10
`define PHY_IDX_EXT_HI    5'h1e
`define PHY_IDX_PAGE      5'h1f
`define PHY_SOFT_RST_BIT  15
`define PHY_CTRL_RESET    16'h1040
`define PHY_PAGE_MAIN     16'h0000
`define PHY_PAGE_EXT1     16'h0001
`define PHY_PAGE_EXT2     16'h0002
`define PHY_EXT_PER_PAGE  6'h0f
`define PHY_EXT_SLOTS     45

`endif

// file: design/afe_cfg_pkg.sv
// types shared by the configuration bank and its bench
// assumes afe_cfg_params.svh is on the include path
`default_nettype none
`include "afe_cfg_params.svh"

package afe_cfg_pkg;

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`REG_ADDR_W-1:0]  addr;
    logic [31:0]             wdata;
  } reg_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  index;
    logic [15:0] wdata;
  } mii_req_t;

  typedef struct packed {
    logic [2:0] squelch;
    logic       impedance;
    logic       slew;
    logic       swap;
  } cfg_image_t;

  typedef enum logic [1:0] {
    page_main = 2'b00,
    page_ext1 = 2'b01,
    page_ext2 = 2'b10
  } phy_page_t;

endpackage

`default_nettype wire

// file: design/usb_afe_interchip_port_config_regs.sv
// upstream port front end / inter-chip configuration bank plus indexed PHY register pages
// assumes one 100 MHz clock, synchronous inputs, and a MAC-side management port
//
// Functional notes
// - termination bit enables 45 kohm on DP/DM
// - bit 28 shows active-low squelch status
// - disconnect sampled at 32nd EOP bit time
// - tune field 26:24 selects squelch trip point
// - protection keeps tune value across USB resets
// - tune default: EEPROM, else OTP, else zero
// - USB or lite reset restores loaded image
// - bit 24 selects USB or inter-chip mode
// - mode bit resets from the strap pin
// - bit 18 selects 40 or 50 ohm driver
// - bit 17 applies 30 percent slew adjust
// - bit 16 swaps data and strobe pins
// - impedance, slew, swap defaults from EEPROM/OTP/zero
// - PHY registers reached only through management port
// - extended page redirects indices 16 to 30
// - indices 0 to 15 ignore the page
// - writing zero to page register returns main
// - indices 13 and 14 hold MMD access
// - control bit 15 soft reset, self clearing
//
// Our own choice: the address-and-strobe port.
`default_nettype none
`include "afe_cfg_params.svh"

module usb_afe_interchip_port_config_regs
  import afe_cfg_pkg::*;
(
  input  wire logic        clk,                      // 100 MHz
  input  wire logic        resetn,                   // async, active low
  input  wire reg_req_t    reg_req,                  // register port request
  output logic [31:0]      reg_rdata,                // read data, cycle after rd
  input  wire mii_req_t    mii_req,                  // management access from MAC
  output logic [15:0]      mii_rdata,                // management read data
  input  wire logic        cfg_load,                 // pulse: config image loaded
  input  wire logic        eeprom_present,           // EEPROM found
  input  wire logic        otp_configured,           // OTP programmed
  input  wire cfg_image_t  eeprom_cfg0,              // stored_squelch_threshold etc.
  input  wire cfg_image_t  otp_cfg,                  // OTP copy of same fields
  input  wire logic        usb_reset,                // pulse: bus reset seen
  input  wire logic        lite_reset,               // pulse: lite reset
  input  wire logic        reset_protect,            // level: protects tune field
  input  wire logic        port_mode_strap,          // strap pin level
  input  wire logic        afe_squelch_raw,          // analog squelch, active low
  input  wire logic        afe_disconnect_raw,       // analog disconnect level
  input  wire logic        hs_eop_bit32,             // pulse: 32nd bit time of EOP
  input  wire logic        hsic_tx_data,             // core data to pads
  input  wire logic        hsic_tx_strobe,           // core strobe to pads
  output logic             hs_termination_on,        // 45 kohm DP/DM termination
  output logic [2:0]       squelch_trip_tune,        // to analog squelch
  output logic             port_mode_select,         // 1 = inter-chip mode
  output logic             driver_impedance_select,  // 1 = 50 ohm
  output logic             data_strobe_slew_adjust,  // 1 = slew adjust on
  output logic             data_strobe_swap,         // 1 = pins exchanged
  output logic             pad_data_out,             // data pad drive
  output logic             pad_strobe_out,           // strobe pad drive
  output logic             phy_soft_reset,           // one-cycle soft reset pulse
  output phy_page_t        phy_page                  // active extended page
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_ext_index(input logic [4:0] idx);
    is_ext_index = (idx >= `PHY_IDX_EXT_LO) && (idx <= `PHY_IDX_EXT_HI);
  endfunction

  // page 0 slots double as the main page 16..30 registers
  function automatic logic [5:0] ext_slot(input phy_page_t pg, input logic [4:0] idx);
    logic [5:0] base;
    base = 6'(pg) * `PHY_EXT_PER_PAGE;
    ext_slot = base + 6'(idx) - 6'(`PHY_IDX_EXT_LO);
  endfunction

  function automatic phy_page_t decode_page(input logic [15:0] v);
    if (v == `PHY_PAGE_EXT1) begin
      decode_page = page_ext1;
    end else if (v == `PHY_PAGE_EXT2) begin
      decode_page = page_ext2;
    end else begin
      decode_page = page_main;
    end
  endfunction

  function automatic cfg_image_t pick_image(input logic ee, input logic otp,
                                            input cfg_image_t ee_v, input cfg_image_t otp_v);
    if (ee) begin
      pick_image = ee_v;
    end else if (otp) begin
      pick_image = otp_v;
    end else begin
      pick_image = '0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  logic       wr_afe;
  logic       wr_port;
  logic       rd_afe;
  logic       rd_port;
  logic       restore;
  logic       strap_taken;
  logic       hs_squelch_active_low;
  logic       hs_line_disconnect;
  logic [15:0] page_reg;
  cfg_image_t image;
  logic [31:0] afe_word;
  logic [31:0] port_word;

  assign wr_afe  = reg_req.wr && (reg_req.addr == `AFE_CTRL_OFFSET);
  assign wr_port = reg_req.wr && (reg_req.addr == `PORT_EN_OFFSET);
  assign rd_afe  = reg_req.rd && (reg_req.addr == `AFE_CTRL_OFFSET);
  assign rd_port = reg_req.rd && (reg_req.addr == `PORT_EN_OFFSET);
  assign restore = usb_reset || lite_reset;

  always_comb begin
    afe_word = '0;
    afe_word[`HS_TERM_BIT] = hs_termination_on;
    afe_word[`HS_SQUELCH_BIT] = hs_squelch_active_low;
    afe_word[`HS_DISC_BIT] = hs_line_disconnect;
    afe_word[`SQU_TUNE_MSB:`SQU_TUNE_LSB] = squelch_trip_tune;
  end

  always_comb begin
    port_word = '0;
    port_word[`PORT_MODE_BIT] = port_mode_select;
    port_word[`DRV_IMP_BIT] = driver_impedance_select;
    port_word[`SLEW_ADJ_BIT] = data_strobe_slew_adjust;
    port_word[`DS_SWAP_BIT] = data_strobe_swap;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration image: last values loaded from EEPROM or OTP

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      image <= '0;
    end else if (cfg_load) begin
      image <= pick_image(eeprom_present, otp_configured, eeprom_cfg0, otp_cfg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // front end control

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_termination_on <= 1'b0;
    end else if (wr_afe) begin
      hs_termination_on <= reg_req.wdata[`HS_TERM_BIT];
    end
  end

  // squelch trip: 000 nominal, 001-101 lower in steps, 110 +25 mV, 111 +12.5 mV
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      squelch_trip_tune <= `SQU_TUNE_RESET;
    end else if (restore && !reset_protect) begin
      squelch_trip_tune <= image.squelch;
    end else if (cfg_load) begin
      squelch_trip_tune <= pick_image(eeprom_present, otp_configured,
                                      eeprom_cfg0, otp_cfg).squelch;
    end else if (wr_afe) begin
      squelch_trip_tune <= reg_req.wdata[`SQU_TUNE_MSB:`SQU_TUNE_LSB];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_squelch_active_low <= 1'b0;
    end else begin
      hs_squelch_active_low <= afe_squelch_raw;
    end
  end

  // the analog level is only trustworthy at the strobe point, so hold between strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_line_disconnect <= 1'b0;
    end else if (hs_eop_bit32) begin
      hs_line_disconnect <= afe_disconnect_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // inter-chip port enable

  // strap is caught on the first edge after release, never under the async reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_mode_select <= 1'b0;
    end else if (!strap_taken) begin
      port_mode_select <= port_mode_strap;
    end else if (wr_port) begin
      port_mode_select <= reg_req.wdata[`PORT_MODE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      driver_impedance_select <= 1'b0;
      data_strobe_slew_adjust <= 1'b0;
      data_strobe_swap        <= 1'b0;
    end else if (restore) begin
      driver_impedance_select <= image.impedance;
      data_strobe_slew_adjust <= image.slew;
      data_strobe_swap        <= image.swap;
    end else if (cfg_load) begin
      driver_impedance_select <= pick_image(eeprom_present, otp_configured,
                                            eeprom_cfg0, otp_cfg).impedance;
      data_strobe_slew_adjust <= pick_image(eeprom_present, otp_configured,
                                            eeprom_cfg0, otp_cfg).slew;
      data_strobe_swap        <= pick_image(eeprom_present, otp_configured,
                                            eeprom_cfg0, otp_cfg).swap;
    end else if (wr_port) begin
      driver_impedance_select <= reg_req.wdata[`DRV_IMP_BIT];
      data_strobe_slew_adjust <= reg_req.wdata[`SLEW_ADJ_BIT];
      data_strobe_swap        <= reg_req.wdata[`DS_SWAP_BIT];
    end
  end

  // one register stage on the pads costs a cycle but keeps them glitch free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pad_data_out   <= 1'b0;
      pad_strobe_out <= 1'b0;
    end else if (data_strobe_swap) begin
      pad_data_out   <= hsic_tx_strobe;
      pad_strobe_out <= hsic_tx_data;
    end else begin
      pad_data_out   <= hsic_tx_data;
      pad_strobe_out <= hsic_tx_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (rd_afe) begin
      reg_rdata <= afe_word;
    end else if (rd_port) begin
      reg_rdata <= port_word;
    end else begin
      reg_rdata <= '0; // unmapped reads and idle cycles; PHY space is not mapped
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PHY register pages behind the management port

  logic [15:0] main_regs [0:15];
  logic [15:0] ext_regs  [0:`PHY_EXT_SLOTS-1];
  logic        mii_rsvd;

  assign mii_rsvd = (mii_req.index == `PHY_IDX_RSVD_A) || (mii_req.index == `PHY_IDX_RSVD_B);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_reg <= `PHY_PAGE_MAIN;
      phy_page <= page_main;
    end else if (mii_req.wr && (mii_req.index == `PHY_IDX_PAGE)) begin
      page_reg <= mii_req.wdata;
      phy_page <= decode_page(mii_req.wdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        main_regs[i] <= '0;
      end
      main_regs[0] <= `PHY_CTRL_RESET;
    end else if (mii_req.wr && !mii_req.index[4] && !mii_rsvd) begin
      main_regs[mii_req.index[3:0]] <= mii_req.wdata;
      if (mii_req.index == `PHY_IDX_CTRL) begin
        main_regs[0][`PHY_SOFT_RST_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `PHY_EXT_SLOTS; i++) begin
        ext_regs[i] <= '0;
      end
    end else if (mii_req.wr && is_ext_index(mii_req.index)) begin
      ext_regs[ext_slot(phy_page, mii_req.index)] <= mii_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phy_soft_reset <= 1'b0;
    end else begin
      phy_soft_reset <= mii_req.wr && (mii_req.index == `PHY_IDX_CTRL)
                        && mii_req.wdata[`PHY_SOFT_RST_BIT];
    end
  end

  // reserved indices 11 and 12 are the manager's problem; they simply read zero here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mii_rdata <= '0;
    end else if (!mii_req.rd || mii_rsvd) begin
      mii_rdata <= '0;
    end else if (mii_req.index == `PHY_IDX_PAGE) begin
      mii_rdata <= page_reg;
    end else if (is_ext_index(mii_req.index)) begin
      mii_rdata <= ext_regs[ext_slot(phy_page, mii_req.index)];
    end else if (mii_req.index == `PHY_IDX_CTRL) begin
      mii_rdata <= {phy_soft_reset, main_regs[0][14:0]};
    end else begin
      mii_rdata <= main_regs[mii_req.index[3:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_term_write:
  assert property (@(posedge clk) disable iff (!resetn)
    wr_afe |=> hs_termination_on == $past(reg_req.wdata[`HS_TERM_BIT]))
    else $error("termination does not follow write");

  a_squelch_read:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_afe |=> reg_rdata[`HS_SQUELCH_BIT] == $past(afe_squelch_raw, 2))
    else $error("squelch read value wrong");

  a_disc_hold:
  assert property (@(posedge clk) disable iff (!resetn)
    !hs_eop_bit32 |=> $stable(hs_line_disconnect))
    else $error("disconnect changed outside strobe");

  a_tune_write:
  assert property (@(posedge clk) disable iff (!resetn)
    wr_afe && !restore && !cfg_load |=>
      squelch_trip_tune == $past(reg_req.wdata[`SQU_TUNE_MSB:`SQU_TUNE_LSB]))
    else $error("tune field not written");

  a_tune_protect:
  assert property (@(posedge clk) disable iff (!resetn)
    restore && reset_protect && !cfg_load && !wr_afe |=> $stable(squelch_trip_tune))
    else $error("protected tune overwritten");

  a_image_pick:
  assert property (@(posedge clk) disable iff (!resetn)
    cfg_load && !eeprom_present && !otp_configured |=> image == '0)
    else $error("empty config not zero");

  a_fields_restore:
  assert property (@(posedge clk) disable iff (!resetn)
    restore |=> data_strobe_swap == $past(image.swap)
               && driver_impedance_select == $past(image.impedance))
    else $error("restore did not reload image");

  a_mode_strap:
  assert property (@(posedge clk) disable iff (!resetn)
    $rose(strap_taken) |-> port_mode_select == $past(port_mode_strap))
    else $error("mode bit not taken from strap");

  a_pin_swap:
  assert property (@(posedge clk) disable iff (!resetn)
    data_strobe_swap |=> pad_data_out == $past(hsic_tx_strobe)
                       && pad_strobe_out == $past(hsic_tx_data))
    else $error("pins not exchanged");

  a_page_exit:
  assert property (@(posedge clk) disable iff (!resetn)
    mii_req.wr && mii_req.index == `PHY_IDX_PAGE && mii_req.wdata == `PHY_PAGE_MAIN
      |=> phy_page == page_main)
    else $error("page not returned to main");

  a_soft_reset:
  assert property (@(posedge clk) disable iff (!resetn)
    phy_soft_reset |-> ##1 (!phy_soft_reset || $past(mii_req.wr)) ##0 !main_regs[0][15])
    else $error("soft reset not self clearing");

  a_reserved_zero:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_port |=> reg_rdata[31:25] == '0 && reg_rdata[23:19] == '0 && reg_rdata[15:0] == '0)
    else $error("reserved bits read nonzero");
endmodule

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the front end / inter-chip configuration bank
// assumes afe_cfg_pkg and afe_cfg_params.svh are compiled ahead of this file
`default_nettype none
`include "afe_cfg_params.svh"

module tb import afe_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk                = 1'b0;
  logic        resetn             = 1'b0;
  reg_req_t    reg_req            = '0;
  mii_req_t    mii_req            = '0;
  logic        cfg_load           = 1'b0;
  logic        eeprom_present     = 1'b0;
  logic        otp_configured     = 1'b0;
  cfg_image_t  eeprom_cfg0        = '0;
  cfg_image_t  otp_cfg            = '0;
  logic        usb_reset          = 1'b0;
  logic        lite_reset         = 1'b0;
  logic        reset_protect      = 1'b0;
  logic        port_mode_strap    = 1'b1;
  logic        afe_squelch_raw    = 1'b0;
  logic        afe_disconnect_raw = 1'b0;
  logic        hs_eop_bit32       = 1'b0;
  logic        hsic_tx_data       = 1'b0;
  logic        hsic_tx_strobe     = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] mii_rdata;
  logic        hs_termination_on, port_mode_select, driver_impedance_select;
  logic        data_strobe_slew_adjust, data_strobe_swap, pad_data_out, pad_strobe_out;
  logic        phy_soft_reset;
  logic [2:0]  squelch_trip_tune;
  phy_page_t   phy_page;
  logic        rd_q               = 1'b0;
  logic        mii_rd_q           = 1'b0;
  logic [31:0] reg_exp[$];
  logic [15:0] mii_exp[$];
  logic [31:0] seed               = 32'h3262;
  int          err_count          = 0;
  int          checks             = 0;
  wire cfg_image_t img_out = {squelch_trip_tune, driver_impedance_select,
                              data_strobe_slew_adjust, data_strobe_swap};

  usb_afe_interchip_port_config_regs uut (.clk, .resetn, .reg_req, .reg_rdata, .mii_req,
    .mii_rdata, .cfg_load, .eeprom_present, .otp_configured, .eeprom_cfg0, .otp_cfg,
    .usb_reset, .lite_reset, .reset_protect, .port_mode_strap, .afe_squelch_raw,
    .afe_disconnect_raw, .hs_eop_bit32, .hsic_tx_data, .hsic_tx_strobe, .hs_termination_on,
    .squelch_trip_tune, .port_mode_select, .driver_impedance_select, .data_strobe_slew_adjust,
    .data_strobe_swap, .pad_data_out, .pad_strobe_out, .phy_soft_reset, .phy_page);

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // strobe drops on the same edge it is taken, so calls never collide in one time step
  task automatic reg_op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    reg_op(1'b1, 1'b0, a, d);
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
    reg_exp.push_back(e);
    reg_op(1'b0, 1'b1, a, 32'h0);
  endtask

  task automatic mii_op(input logic w, input logic r, input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    mii_req <= '{wr: w, rd: r, index: i, wdata: d};
    @(posedge clk);
    mii_req <= '0;
  endtask

  task automatic mii_rd(input logic [4:0] i, input logic [15:0] e);
    mii_exp.push_back(e);
    mii_op(1'b0, 1'b1, i, 16'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe, zero at all other times
  always @(posedge clk) begin
    rd_q     <= reg_req.rd;
    mii_rd_q <= mii_req.rd;
  end

  always @(negedge clk) begin
    if (rd_q && reg_exp.size() > 0) begin
      chk(reg_rdata, reg_exp.pop_front());
    end else begin
      chk(reg_rdata, 32'h0);
    end
    if (mii_rd_q && mii_exp.size() > 0) begin
      chk({16'h0, mii_rdata}, {16'h0, mii_exp.pop_front()});
    end else begin
      chk({16'h0, mii_rdata}, 32'h0);
    end
  end

  // whole run is well under 2000 cycles; this limit only catches a hang
  initial begin
    #200_000;
    err_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, afe, r;
    logic [31:0] pv[3];
    cfg_image_t  ee, ot, ex, w, rx;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(port_mode_select, 1);
    chk(img_out, `SQU_TUNE_RESET);
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      d[26:24] = i[2:0];
      reg_wr(`AFE_CTRL_OFFSET, d);
      @(negedge clk);
      chk({hs_termination_on, squelch_trip_tune}, {d[29], i[2:0]});
      afe = {2'b0, d[29], 2'b0, i[2:0], 24'h0};
      reg_rd(`AFE_CTRL_OFFSET, afe);
    end
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      d[16] = i[0];
      reg_wr(`PORT_EN_OFFSET, d);
      @(negedge clk);
      chk({port_mode_select, driver_impedance_select, data_strobe_slew_adjust,
           data_strobe_swap}, {d[24], d[18:16]});
      reg_rd(`PORT_EN_OFFSET, d & 32'h0107_0000);
      @(posedge clk);
      {hsic_tx_data, hsic_tx_strobe} <= d[1:0];
      @(posedge clk);
      @(negedge clk);
      chk({pad_data_out, pad_strobe_out}, d[16] ? {d[0], d[1]} : d[1:0]);
    end
    reg_wr(12'h0c4, 32'hffff_ffff);
    reg_rd(12'h0c4, 32'h0);
    $display("register bank test done");
    @(posedge clk);
    afe_squelch_raw    <= 1'b1;
    afe_disconnect_raw <= 1'b1;
    reg_rd(`AFE_CTRL_OFFSET, afe | 32'h1000_0000);
    @(posedge clk);
    hs_eop_bit32 <= 1'b1;
    @(posedge clk);
    hs_eop_bit32       <= 1'b0;
    afe_disconnect_raw <= 1'b0;
    afe_squelch_raw    <= 1'b0;
    reg_rd(`AFE_CTRL_OFFSET, afe | 32'h0800_0000);
    $display("status bit test done");
    for (int s = 0; s < 3; s++) begin
      r = rnd();
      ee = r[5:0];
      ot = r[11:6];
      @(posedge clk);
      reset_protect  <= 1'b0;
      eeprom_cfg0    <= ee;
      otp_cfg        <= ot;
      eeprom_present <= (s == 0);
      otp_configured <= (s < 2);
      cfg_load       <= 1'b1;
      @(posedge clk);
      cfg_load <= 1'b0;
      ex = (s == 0) ? ee : (s == 1) ? ot : '0;
      @(negedge clk);
      chk(img_out, ex);
      w = ~ex;
      reg_wr(`AFE_CTRL_OFFSET, {5'b0, w.squelch, 24'h0});
      reg_wr(`PORT_EN_OFFSET, {7'b0, 1'b1, 5'b0, w.impedance, w.slew, w.swap, 16'h0});
      @(negedge clk);
      chk(img_out, w);
      // the image inputs move here so that only the last loaded copy can be restored
      @(posedge clk);
      usb_reset     <= ~s[0];
      lite_reset    <= s[0];
      reset_protect <= (s == 1);
      eeprom_cfg0   <= ~ee;
      otp_cfg       <= ~ot;
      @(posedge clk);
      usb_reset  <= 1'b0;
      lite_reset <= 1'b0;
      rx = ex;
      if (s == 1) rx.squelch = w.squelch;
      @(negedge clk);
      chk(img_out, rx);
    end
    @(posedge clk);
    reset_protect <= 1'b0;
    $display("image load and restore test done");
    mii_rd(`PHY_IDX_CTRL, `PHY_CTRL_RESET);
    mii_op(1'b1, 1'b0, `PHY_IDX_CTRL, 16'h9040);
    @(negedge clk);
    chk(phy_soft_reset, 1);
    @(negedge clk);
    chk(phy_soft_reset, 0);
    mii_rd(`PHY_IDX_CTRL, `PHY_CTRL_RESET);
    mii_op(1'b1, 1'b0, `PHY_IDX_RSVD_A, 16'hffff);
    mii_rd(`PHY_IDX_RSVD_A, 16'h0);
    for (int p = 0; p < 3; p++) begin
      mii_op(1'b1, 1'b0, `PHY_IDX_PAGE, p[15:0]);
      @(negedge clk);
      chk(phy_page, p);
      pv[p] = rnd();
      mii_op(1'b1, 1'b0, `PHY_IDX_EXT_LO, pv[p][15:0]);
      mii_op(1'b1, 1'b0, `PHY_IDX_EXT_HI, pv[p][31:16]);
      mii_op(1'b1, 1'b0, `PHY_IDX_MMD_CTRL, pv[p][23:8]);
    end
    for (int p = 2; p >= 0; p--) begin
      mii_op(1'b1, 1'b0, `PHY_IDX_PAGE, p[15:0]);
      mii_rd(`PHY_IDX_PAGE, p[15:0]);
      mii_rd(`PHY_IDX_EXT_LO, pv[p][15:0]);
      mii_rd(`PHY_IDX_EXT_HI, pv[p][31:16]);
      mii_rd(`PHY_IDX_MMD_CTRL, pv[2][23:8]);
    end
    $display("phy page test done");
    @(posedge clk);
    resetn          <= 1'b0;
    port_mode_strap <= 1'b0;
    @(negedge clk);
    chk({port_mode_select, phy_page, img_out}, 0);
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(port_mode_select, 0);
    reg_rd(`PORT_EN_OFFSET, 32'h0);
    $display("second reset test done");
    repeat (2) @(posedge clk);
    close_out();
  end

endmodule

`default_nettype wire
